// file: src/dpac_defs.vh
// Purpose: constants for the debug port access-interface control block
// Assumes: 8-bit registers, 4-bit register index from the access layer
// Notes: offsets are register indices on the port's own register access
`ifndef DPAC_DEFS_VH
`define DPAC_DEFS_VH
`define DPAC_OFS_PHY_CTRL 4'h3
`define DPAC_OFS_KEY_STAT 4'h7
`define DPAC_OFS_RST_REQ 4'h8
`define DPAC_OFS_CLK_SEL 4'h9
`define DPAC_OFS_SYS_CTRL 4'ha
`define DPAC_OFS_SYS_STAT 4'hb
`define DPAC_OFS_CRC_STAT 4'hc
`define DPAC_BIT_NACK_DIS 4
`define DPAC_BIT_CCDET_DIS 3
`define DPAC_BIT_PORT_DIS 2
`define DPAC_BIT_UROW_KEY 5
`define DPAC_BIT_NVM_KEY 4
`define DPAC_BIT_ERASE_KEY 3
`define DPAC_BIT_UROW_DONE 1
`define DPAC_BIT_CLK_REQ 0
`define DPAC_BIT_RST_ACT 5
`define DPAC_BIT_SLEEP 4
`define DPAC_BIT_NVM_PROG 3
`define DPAC_BIT_UROW_PROG 2
`define DPAC_BIT_LOCK 0
`define DPAC_RST_CODE_RESET 8'h59
`define DPAC_RST_CODE_RUN 8'h00
`define DPAC_CLKSEL_RSVD 2'h0
`define DPAC_CLKSEL_16M 2'h1
`define DPAC_CLKSEL_8M 2'h2
`define DPAC_CLKSEL_4M 2'h3
`define DPAC_CLKSEL_RESET 2'h3
`define DPAC_CLKSEL_MSB 1
`define DPAC_SYNC_LOCK 7
`define DPAC_SYNC_UROW 6
`define DPAC_SYNC_SLEEP 5
`define DPAC_SYNC_RST 4
`define DPAC_SYNC_CRC_MSB 2
`define DPAC_CRC_OFF 3'h0
`define DPAC_CRC_BUSY 3'h1
`define DPAC_CRC_OK 3'h2
`define DPAC_CRC_FAIL 3'h4
`define DPAC_SYS_STAT_RESET 8'h01
`define DPAC_SYS_HZ 100000000
`define DPAC_HZ_16M 16000000
`define DPAC_HZ_8M 8000000
`define DPAC_HZ_4M 4000000
`endif

// file: src/dpac_clk_div.v
// Purpose: port clock enable divider, one-cycle pulse at the selected rate
// Assumes: sys_clk at the rate in the defs header
// Notes: divisors round down to whole sys_clk periods (16 MHz -> every 6 cycles)
`timescale 1ns/10ps
`include "dpac_defs.vh"
module dpac_clk_div #(
  parameter CNT_W = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire run,
  input wire [1:0] clkSel,
  output reg portTick
);
  localparam integer DIV16_I = `DPAC_SYS_HZ / `DPAC_HZ_16M;
  localparam integer DIV8_I = `DPAC_SYS_HZ / `DPAC_HZ_8M;
  localparam integer DIV4_I = `DPAC_SYS_HZ / `DPAC_HZ_4M;
  localparam [CNT_W-1:0] DIV16 = DIV16_I[CNT_W-1:0];
  localparam [CNT_W-1:0] DIV8 = DIV8_I[CNT_W-1:0];
  localparam [CNT_W-1:0] DIV4 = DIV4_I[CNT_W-1:0];
  reg [CNT_W-1:0] cnt;
  reg [CNT_W-1:0] limit;
  always @* begin
    case (clkSel)
      `DPAC_CLKSEL_16M: limit = DIV16;
      `DPAC_CLKSEL_8M: limit = DIV8;
      default: limit = DIV4;
    endcase
  end
  always @(posedge sys_clk) begin
    if (!nrst || !run) begin
      cnt <= {CNT_W{1'b0}};
      portTick <= 1'b0;
    end else if (cnt >= limit - 1'b1) begin
      cnt <= {CNT_W{1'b0}};
      portTick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      portTick <= 1'b0;
    end
  end
endmodule // dpac_clk_div

// file: src/dpac_ctrl.v
// Purpose: control and status registers of the single-wire debug port access interface
// Assumes: access layer presents decoded register writes/reads and key-decode pulses
// Notes: system-side status arrives asynchronously and is synchronised here
`timescale 1ns/10ps
`include "dpac_defs.vh"
module dpac_ctrl #(
  parameter DIV_W = 8
) (
  input wire sys_clk,
  input wire nrst,
  input wire portEnable,
  input wire regWrite,
  input wire regRead,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire userRowKeyDecoded,
  input wire nvmKeyDecoded,
  input wire eraseKeyDecoded,
  input wire nvmProgStart,
  input wire ldStActive,
  input wire sysInReset,
  input wire sysInSleep,
  input wire sysUserRowProgReady,
  input wire sysLocked,
  input wire [2:0] crcState,
  output wire nackDisable,
  output wire contentionDetectDisable,
  output wire sendResetNack,
  output wire portDisabled,
  output wire systemResetRequest,
  output wire systemClockRequest,
  output reg userRowDone,
  output wire [1:0] portClockSelect,
  output wire portClockTick
);
  reg nack_disable;
  reg contention_detect_disable;
  reg userRowKeyOk;
  reg nvmKeyOk;
  reg eraseKeyOk;
  reg [7:0] resetRequestCode;
  reg [1:0] clkSel;
  reg system_clock_request;
  reg nvmProgFlag;
  reg rstSeen;
  reg [7:0] metaSys;
  reg [7:0] syncSys;
  reg [2:0] crcStatus;
  reg portOn;
  reg holdReset;
  reg prevReset;
  reg freshOn;
  reg [2:0] crcPrev;
  wire enabled;
  wire wrPhy;
  wire wrKey;
  wire wrRst;
  wire wrClk;
  wire wrSys;
  wire rdSys;
  wire portReset;
  wire sysResetNow;
  wire wrRstGo;
  wire wrRstRun;
  wire [7:0] sysStatus;

  // one decode helper keeps all strobes identical in timing
  function hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign wrPhy = regWrite && hit(regAddr, `DPAC_OFS_PHY_CTRL);
  assign wrKey = regWrite && hit(regAddr, `DPAC_OFS_KEY_STAT);
  assign wrRst = regWrite && hit(regAddr, `DPAC_OFS_RST_REQ);
  assign wrClk = regWrite && hit(regAddr, `DPAC_OFS_CLK_SEL);
  assign wrSys = regWrite && hit(regAddr, `DPAC_OFS_SYS_CTRL);
  assign rdSys = regRead && hit(regAddr, `DPAC_OFS_SYS_STAT);
  // both reset-register codes decoded once; every other value is reserved
  assign wrRstGo = wrRst && (regWdata == `DPAC_RST_CODE_RESET);
  assign wrRstRun = wrRst && (regWdata == `DPAC_RST_CODE_RUN);

  // port reset: chip reset, port not enabled, or disable bit written
  assign portReset = !nrst || !portOn || (wrPhy && regWdata[`DPAC_BIT_PORT_DIS]);

  // enable tracking; system reset request does not reach this
  always @(posedge sys_clk) begin
    if (!nrst) begin
      portOn <= 1'b0;
      prevReset <= 1'b0;
    end else begin
      prevReset <= portEnable;
      if (portEnable && !prevReset)
        portOn <= 1'b1;
      else if (!portEnable || (wrPhy && regWdata[`DPAC_BIT_PORT_DIS]))
        portOn <= 1'b0;
    end
  end
  assign enabled = portOn;
  assign portDisabled = !portOn;

  // system-side levels: two flops before use
  always @(posedge sys_clk) begin
    if (!nrst) begin
      metaSys <= 8'h00;
      syncSys <= 8'h00;
    end else begin
      metaSys <= {sysLocked, sysUserRowProgReady, sysInSleep, sysInReset, 1'b0, crcState};
      syncSys <= metaSys;
    end
  end

  // first cycle after the port leaves reset, for the clock request default
  always @(posedge sys_clk) begin
    if (portReset) begin
      freshOn <= 1'b1;
    end else begin
      freshOn <= 1'b0;
    end
  end

  // the disable bit is not stored: writing it resets the whole port
  always @(posedge sys_clk) begin
    if (portReset) begin
      nack_disable <= 1'b0;
      contention_detect_disable <= 1'b0;
    end else if (wrPhy) begin
      nack_disable <= regWdata[`DPAC_BIT_NACK_DIS];
      contention_detect_disable <= regWdata[`DPAC_BIT_CCDET_DIS];
    end
  end

  // clock request: on by default once enabled, then under debugger control
  always @(posedge sys_clk) begin
    if (portReset) begin
      system_clock_request <= 1'b0;
    end else if (wrSys) begin
      system_clock_request <= regWdata[`DPAC_BIT_CLK_REQ];
    end else if (freshOn) begin
      system_clock_request <= 1'b1;
    end
  end

  // key flags: a decode in the same cycle as a clear wins
  always @(posedge sys_clk) begin
    if (portReset) begin
      userRowKeyOk <= 1'b0;
    end else if (userRowKeyDecoded) begin
      userRowKeyOk <= 1'b1;
    end else if (wrKey && regWdata[`DPAC_BIT_UROW_KEY]) begin
      userRowKeyOk <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (portReset) begin
      nvmKeyOk <= 1'b0;
      nvmProgFlag <= 1'b0;
    end else begin
      if (nvmKeyDecoded) begin
        nvmKeyOk <= 1'b1;
      end else if (nvmProgStart) begin
        nvmKeyOk <= 1'b0;
      end
      // programming flag only rises on a start backed by the key
      if (nvmProgStart && nvmKeyOk) begin
        nvmProgFlag <= 1'b1;
      end else if (wrRstRun) begin
        nvmProgFlag <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (portReset) begin
      eraseKeyOk <= 1'b0;
    end else if (eraseKeyDecoded) begin
      eraseKeyOk <= 1'b1;
    end else if (wrRstGo) begin
      eraseKeyOk <= 1'b0;
    end
  end

  // reserved codes dropped, so a stray write can neither assert nor release reset
  always @(posedge sys_clk) begin
    if (portReset) begin
      resetRequestCode <= `DPAC_RST_CODE_RUN;
      holdReset <= 1'b0;
    end else if (wrRstGo) begin
      resetRequestCode <= regWdata;
      holdReset <= 1'b1;
    end else if (wrRstRun) begin
      resetRequestCode <= regWdata;
      holdReset <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (portReset) begin
      clkSel <= `DPAC_CLKSEL_RESET;
    end else if (wrClk && regWdata[`DPAC_CLKSEL_MSB:0] != `DPAC_CLKSEL_RSVD) begin
      clkSel <= regWdata[`DPAC_CLKSEL_MSB:0];
    end
  end

  // one-cycle start pulse, refused until the user row key has decoded
  always @(posedge sys_clk) begin
    if (portReset) begin
      userRowDone <= 1'b0;
    end else begin
      userRowDone <= wrSys && regWdata[`DPAC_BIT_UROW_DONE] && userRowKeyOk;
    end
  end

  // sticky so a short system reset is not missed; a read clears it,
  // but a reset still present wins over the read
  always @(posedge sys_clk) begin
    if (portReset) begin
      rstSeen <= 1'b0;
    end else if (sysResetNow) begin
      rstSeen <= 1'b1;
    end else if (rdSys) begin
      rstSeen <= 1'b0;
    end
  end

  // crc word crosses bit by bit: take it only once two samples agree,
  // so a one-hot change never shows a mixed code
  always @(posedge sys_clk) begin
    if (portReset) begin
      crcPrev <= `DPAC_CRC_OFF;
      crcStatus <= `DPAC_CRC_OFF;
    end else begin
      crcPrev <= syncSys[`DPAC_SYNC_CRC_MSB:0];
      if (syncSys[`DPAC_SYNC_CRC_MSB:0] == crcPrev) begin
        crcStatus <= crcPrev;
      end
    end
  end

  assign nackDisable = nack_disable;
  assign contentionDetectDisable = contention_detect_disable;
  // system reset from either side: the synchronised level or our own hold
  assign sysResetNow = syncSys[`DPAC_SYNC_RST] || holdReset;
  // nack only while not disabled, system reset hits a load/store in progress
  assign sendResetNack = enabled && !nack_disable && ldStActive && sysResetNow;
  // system reset output; port state is untouched by it
  assign systemResetRequest = holdReset;
  assign systemClockRequest = enabled && system_clock_request;
  assign portClockSelect = clkSel;
  // lock reads as set while the port is off, matching the register's reset value
  assign sysStatus = {2'h0, rstSeen || sysResetNow, syncSys[`DPAC_SYNC_SLEEP], nvmProgFlag,
      syncSys[`DPAC_SYNC_UROW], 1'b0, !enabled || syncSys[`DPAC_SYNC_LOCK]};

  always @* begin
    case (regAddr)
      `DPAC_OFS_PHY_CTRL: regRdata = {3'h0, nack_disable, contention_detect_disable, 3'h0};
      `DPAC_OFS_KEY_STAT: regRdata = {2'h0, userRowKeyOk, nvmKeyOk, eraseKeyOk, 3'h0};
      `DPAC_OFS_RST_REQ: regRdata = resetRequestCode;
      `DPAC_OFS_CLK_SEL: regRdata = {6'h00, clkSel};
      `DPAC_OFS_SYS_CTRL: regRdata = {7'h00, system_clock_request};
      `DPAC_OFS_SYS_STAT: regRdata = sysStatus;
      `DPAC_OFS_CRC_STAT: regRdata = {5'h00, crcStatus};
      default: regRdata = 8'h00;
    endcase
  end

  dpac_clk_div #(
    .CNT_W(DIV_W)
  ) u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(enabled),
    .clkSel(clkSel),
    .portTick(portClockTick)
  );
endmodule // dpac_ctrl

// file: tb/dpac_ctrl_assertions.sv
// Purpose: port-level checks on the debug port control block
// Assumes: ports as declared on dpac_ctrl, one clock domain
// Notes: bound to every dpac_ctrl instance after the module
`timescale 1ns/10ps
module dpac_ctrl_assertions (
  input wire sys_clk,
  input wire nrst,
  input wire portEnable,
  input wire regWrite,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire nackDisable,
  input wire sendResetNack,
  input wire portDisabled,
  input wire systemResetRequest,
  input wire systemClockRequest,
  input wire userRowDone,
  input wire [1:0] portClockSelect
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // writes while disabled are refused, so only live writes count
  wire wOn = regWrite && portEnable && !portDisabled;
  a_reset_code_sets: assert property (wOn && regAddr == 4'h8 && regWdata == 8'h59 |=> systemResetRequest)
    else $error("reset code did not raise the request");
  a_run_code_clears: assert property (wOn && regAddr == 4'h8 && regWdata == 8'h00 |=> !systemResetRequest)
    else $error("run code did not drop the request");
  a_rsvd_code_holds: assert property (wOn && regAddr == 4'h8 && regWdata != 8'h59 && regWdata != 8'h00
    |=> $stable(systemResetRequest))
    else $error("reserved reset code changed the request");
  a_clk_sel_takes: assert property (wOn && regAddr == 4'h9 && regWdata[1:0] != 2'h0
    |=> portClockSelect == $past(regWdata[1:0]))
    else $error("clock select not taken");
  a_clk_rsvd_holds: assert property (wOn && regAddr == 4'h9 && regWdata[1:0] == 2'h0 |=> $stable(portClockSelect))
    else $error("reserved clock select taken");
  a_nack_gate_off: assert property (nackDisable |-> !sendResetNack)
    else $error("nack sent while disabled");
  a_disable_drops_req: assert property (wOn && regAddr == 4'h3 && regWdata[2] |=> portDisabled && !systemClockRequest)
    else $error("port disable did not take effect");
  a_done_from_write: assert property (userRowDone |-> $past(regWrite && regAddr == 4'ha && regWdata[1]))
    else $error("user row done without a write");
  c_done: cover property (userRowDone);
  c_reset: cover property ($rose(systemResetRequest));
  c_disable: cover property ($rose(portDisabled));
endmodule // dpac_ctrl_assertions
bind dpac_ctrl dpac_ctrl_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .portEnable(portEnable),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .nackDisable(nackDisable),
  .sendResetNack(sendResetNack), .portDisabled(portDisabled), .systemResetRequest(systemResetRequest),
  .systemClockRequest(systemClockRequest), .userRowDone(userRowDone), .portClockSelect(portClockSelect));

// file: tb/dpac_dbg_model.sv
// Purpose: debugger side of the register access
// Assumes: one access at a time, launched 1 ns after a rising edge
// Notes: keeps the far side's session and ordering duties
`timescale 1ns/10ps
module dpac_dbg_model #(
  parameter BROWNOUT_TOP = 1
) (
  input wire sys_clk,
  input wire [7:0] regRdata,
  output reg regWrite,
  output reg regRead,
  output reg [3:0] regAddr,
  output reg [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge sys_clk);
      #1;
      regWrite = 1'b0;
      regWdata = ~d; // no stale data after release
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge sys_clk);
      #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge sys_clk);
      d = regRdata;
      #1;
      regRead = 1'b0;
    end
  endtask
  task end_session; wr(4'h7, 8'h20); endtask
  // only after the row data sits in ram; keeps the clock request
  task row_done; wr(4'ha, 8'h03); endtask
  // faster rates only with the brownout detector at its top level
  task set_clock(input [1:0] s); wr(4'h9, {6'h00, BROWNOUT_TOP ? s : 2'h3}); endtask
  task reset_system; begin wr(4'h8, 8'h59); wr(4'h8, 8'h00); end endtask
endmodule // dpac_dbg_model

// file: tb/tb.sv
// Purpose: self-checking bench for the debug port control block
// Assumes: inputs change 1 ns after a rising edge
// Notes: reset values first, then the row table, then hand-written cases
`timescale 1ns/10ps
module tb;
  reg sys_clk, nrst, portEnable, ldStActive, sysInReset, sysInSleep, sysUserRowProgReady, sysLocked;
  reg userRowKeyDecoded, nvmKeyDecoded, eraseKeyDecoded, nvmProgStart;
  reg [2:0] crcState;
  reg [7:0] rv;
  wire regWrite, regRead, nackDisable, contentionDetectDisable, sendResetNack, portDisabled;
  wire systemResetRequest, systemClockRequest, userRowDone, portClockTick;
  wire [3:0] regAddr;
  wire [7:0] regWdata, regRdata;
  wire [1:0] portClockSelect;
  integer n_mismatch, comparisons, cyc, i, t;
  // addr, write data, read back
  logic [19:0] rows [8] = '{20'h30808, 20'h31010, 20'h90101, 20'h90202, 20'h90002, 20'h90303, 20'ha0000, 20'ha0101};
  dpac_dbg_model dbg (.sys_clk(sys_clk), .regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata));
  dpac_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .portEnable(portEnable), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .userRowKeyDecoded(userRowKeyDecoded), .nvmKeyDecoded(nvmKeyDecoded), .eraseKeyDecoded(eraseKeyDecoded),
    .nvmProgStart(nvmProgStart), .ldStActive(ldStActive), .sysInReset(sysInReset), .sysInSleep(sysInSleep),
    .sysUserRowProgReady(sysUserRowProgReady), .sysLocked(sysLocked), .crcState(crcState),
    .nackDisable(nackDisable), .contentionDetectDisable(contentionDetectDisable), .sendResetNack(sendResetNack),
    .portDisabled(portDisabled), .systemResetRequest(systemResetRequest), .systemClockRequest(systemClockRequest),
    .userRowDone(userRowDone), .portClockSelect(portClockSelect), .portClockTick(portClockTick));
  task chk(input [7:0] g, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rdc(input [3:0] a, input [7:0] e); begin dbg.rd(a, rv); chk(rv, e); end endtask
  task w(input integer n); begin repeat (n) @(posedge sys_clk); #1; end endtask
  task pulse(input [3:0] p);
    begin
      {userRowKeyDecoded, nvmKeyDecoded, eraseKeyDecoded, nvmProgStart} = p;
      w(1);
      {userRowKeyDecoded, nvmKeyDecoded, eraseKeyDecoded, nvmProgStart} = 4'h0;
    end
  endtask
  task gap(output integer n); begin n = 0; do begin w(1); n = n + 1; end while (portClockTick !== 1'b1 && n < 60); end endtask
  task report_and_stop;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin n_mismatch = n_mismatch + 1; report_and_stop; end
  end
  initial begin
    {n_mismatch, comparisons, cyc} = 0;
    {nrst, portEnable, ldStActive, sysInReset, sysInSleep, sysUserRowProgReady, crcState} = 0;
    sysLocked = 1'b1;
    pulse(4'h0);
    w(10);
    nrst = 1'b1;
    rdc(4'hb, 8'h01);
    dbg.wr(4'h8, 8'h59);
    chk(systemResetRequest, 8'h00);
    portEnable = 1'b1;
    w(3);
    rdc(4'h3, 8'h00);
    rdc(4'h9, 8'h03);
    rdc(4'ha, 8'h01);
    for (i = 0; i < 8; i = i + 1) begin
      dbg.wr(rows[i][19:16], rows[i][15:8]);
      rdc(rows[i][19:16], rows[i][7:0]);
    end
    chk({nackDisable, contentionDetectDisable}, 8'h02);
    dbg.wr(4'ha, 8'h03);
    chk(userRowDone, 8'h00);
    pulse(4'h8);
    rdc(4'h7, 8'h20);
    dbg.row_done;
    chk(userRowDone, 8'h01);
    dbg.end_session;
    rdc(4'h7, 8'h00);
    pulse(4'h4);
    rdc(4'h7, 8'h10);
    pulse(4'h1);
    rdc(4'h7, 8'h00);
    rdc(4'hb, 8'h09);
    pulse(4'h2);
    rdc(4'h7, 8'h08);
    ldStActive = 1'b1;
    dbg.wr(4'h8, 8'h59);
    chk({systemResetRequest, portDisabled, sendResetNack}, 8'h04);
    rdc(4'h7, 8'h00);
    dbg.wr(4'h8, 8'h33);
    chk(systemResetRequest, 8'h01);
    dbg.wr(4'h3, 8'h08);
    chk({nackDisable, contentionDetectDisable, sendResetNack}, 8'h03);
    dbg.reset_system;
    ldStActive = 1'b0;
    chk(systemResetRequest, 8'h00);
    rdc(4'hb, 8'h21);
    rdc(4'hb, 8'h01);
    {sysInReset, sysInSleep, sysUserRowProgReady, sysLocked} = 4'he;
    w(5);
    rdc(4'hb, 8'h34);
    sysInReset = 1'b0;
    w(5);
    rdc(4'hb, 8'h34);
    rdc(4'hb, 8'h14);
    for (i = 0; i < 4; i = i + 1) begin crcState = (i < 3) ? 3'h1 << i : 3'h0; w(5); rdc(4'hc, {5'h0, crcState}); end
    for (i = 1; i < 4; i = i + 1) begin dbg.set_clock(i); gap(t); gap(t); gap(t); chk(t, i == 1 ? 6 : i == 2 ? 12 : 25); end
    dbg.wr(4'h3, 8'h14);
    chk({portDisabled, systemClockRequest}, 8'h02);
    portEnable = 1'b0;
    w(2);
    portEnable = 1'b1;
    w(3);
    rdc(4'ha, 8'h01);
    nrst = 1'b0;
    w(3);
    chk({portDisabled, systemClockRequest}, 8'h02);
    nrst = 1'b1;
    w(3);
    chk({portDisabled, systemClockRequest}, 8'h01);
    rdc(4'h9, 8'h03);
    report_and_stop;
  end
endmodule // tb
